// ===== rtl/pllc_top.sv
// Purpose: PLL relock control, system clock selection and sleep clocking.
// Assumes: main_osc_tick_i is a one-cycle pulse per main oscillator period.
// Notes:   APB slave answers in the second access cycle.
// Functional notes
// - Crystal change retranslates and applies PLL settings.
// - Translation readable when main oscillator feeds PLL.
// - PLL held powered down after reset.
// - PLL output halved before system divisor.
// - Extended source 0x7 makes RTC the reference.
// - PLL has normal and power-down modes.
// - Relock on crystal change or power-up only.
// - Relock down counter loads 0x1200, main osc.
// - PLL unusable as system clock until expired.
// - Stay on oscillator until PLL stable.
// - Lock raw flag, optional lock interrupt.
// - Run mode clocks core and run-gated peripherals.
// - Sleep stops core, keeps system clock.
// - Auto gating picks sleep/deep gates, else run.
// - Wait instruction enters sleep or deep-sleep.
// - Deep-sleep source main osc or internal.
// - Deep-sleep powers PLL down, overrides divisor only if PLL was powered up.
// - Deep exit restores clock before gates.
// - Hibernate exit is an ordinary power-on reset.
// - Divisor equals field value plus one; one when bypassed without the divider.
// - Extended config overrides base fields when selected.
`include "pllc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pllc_top
    import pllc_pkg::*;
#(
    parameter int NGATE = 3,
    parameter logic [12:0] RELOCK_INIT = 13'(`PLLC_RELOCK_INIT)
)(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic main_osc_tick_i,
    input wire logic wfi_i,
    input wire logic deepsleep_en_i,
    input wire logic wake_irq_i,
    output logic [1:0] sysclk_src_o,
    output logic [6:0] sysclk_divisor_o,
    output logic pll_prediv2_o,
    output logic pll_pdn_o,
    output logic [13:0] pll_cfg_o,
    output logic pll_ref_rtc_o,
    output logic main_osc_pdn_o,
    output logic int_osc_pdn_o,
    output logic cpu_clk_en_o,
    output logic [NGATE*32-1:0] periph_clk_en_o,
    output logic pll_lock_o,
    output logic irq_o
);

    // Translation stand-in: reference divider from the crystal code and a
    // feedback count that falls as the crystal rises.
    function automatic logic [13:0] xlate(input logic [4:0] x);
        logic [8:0] f;
        f = `PLLC_XLATE_FBASE - {4'h0, x};
        return {x, f};
    endfunction

    logic [31:0] run_cfg_r, run_cfg_nxt;
    logic [31:0] ext_cfg_r, ext_cfg_nxt;
    logic [31:0] ds_cfg_r, ds_cfg_nxt;
    logic [31:0] rgate_r [NGATE];
    logic [31:0] rgate_nxt [NGATE];
    logic [31:0] sgate_r [NGATE];
    logic [31:0] sgate_nxt [NGATE];
    logic [31:0] dgate_r [NGATE];
    logic [31:0] dgate_nxt [NGATE];
    logic mask_r, mask_nxt;
    logic lock_r, lock_nxt;
    logic [4:0] crystal_select_prev_r, crystal_select_prev_nxt;
    logic pll_on_prev_r, pll_on_prev_nxt;
    logic [12:0] cnt_r, cnt_nxt;
    pllc_mode_t mode_r, mode_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic [1:0] src_nxt;
    logic [6:0] divisor_nxt;
    logic pdn_nxt, main_osc_pdn_nxt, iosc_pdn_nxt, cpu_en_nxt;
    logic [NGATE*32-1:0] periph_nxt;

    logic use_ext, bypass_eff, pdn_eff, pll_on, trigger, pll_ready;
    logic auto_gate, ds_internal, wr_en, rd_en, hit;
    logic [5:0] div_eff, run_div;
    pllc_src_t osc_eff, run_src;

    // Extended fields win over the base ones when selected.
    always_comb
    begin
        use_ext = ext_cfg_r[`PLLC_RX_USE];
        if (use_ext)
        begin
            bypass_eff = ext_cfg_r[`PLLC_RX_BYPASS];
            pdn_eff = ext_cfg_r[`PLLC_RX_PWRDN];
            div_eff = ext_cfg_r[`PLLC_RX_DIV];
            if (ext_cfg_r[`PLLC_RX_OSC] == `PLLC_OSC_EXT_RTC)
                osc_eff = PLLC_SRC_RTC_OSC;
            else if (ext_cfg_r[`PLLC_RX_OSC] == 3'h0)
                osc_eff = PLLC_SRC_MAIN_OSC;
            else
                osc_eff = PLLC_SRC_INT_OSC;
        end
        else
        begin
            bypass_eff = run_cfg_r[`PLLC_RC_BYPASS];
            pdn_eff = run_cfg_r[`PLLC_RC_PWRDN];
            // Bypassed with the divider unused runs the source undivided.
            if (bypass_eff && !run_cfg_r[`PLLC_RC_USEDIV])
                div_eff = 6'h00;
            else
                div_eff = {2'h0, run_cfg_r[`PLLC_RC_DIV]};
            osc_eff = (run_cfg_r[`PLLC_RC_OSC] == 2'h0) ?
                PLLC_SRC_MAIN_OSC : PLLC_SRC_INT_OSC;
        end
    end

    // The PLL runs only when software clears power-down outside deep-sleep.
    assign pll_on = !pdn_eff && (mode_r != PLLC_ST_DEEP);
    assign trigger = (crystal_select_prev_r != run_cfg_r[`PLLC_RC_CRYSTAL_SELECT]) ||
        (pll_on && !pll_on_prev_r);
    assign pll_ready = pll_on_prev_r && (cnt_r == 13'h0000) && !trigger;
    // Until the counter expires the chosen oscillator keeps clocking.
    assign run_src = (!bypass_eff && pll_on && pll_ready) ?
        PLLC_SRC_PLL : osc_eff;
    assign run_div = div_eff;
    assign auto_gate = run_cfg_r[`PLLC_RC_AUTOGATE];
    assign ds_internal = (ds_cfg_r[`PLLC_DS_OSC] != 2'h0);

    // Relock counter and its crystal-select and power-up history.
    always_comb
    begin
        crystal_select_prev_nxt = run_cfg_r[`PLLC_RC_CRYSTAL_SELECT];
        pll_on_prev_nxt = pll_on;
        cnt_nxt = cnt_r;
        if (trigger)
            cnt_nxt = RELOCK_INIT;
        else if (main_osc_tick_i && cnt_r != 13'h0000)
            cnt_nxt = cnt_r - 13'h0001;
    end

    // Power mode sequencing; restore comes before gates reopen.
    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            PLLC_ST_RUN:
                if (wfi_i)
                    mode_nxt = deepsleep_en_i ?
                        PLLC_ST_DEEP : PLLC_ST_SLEEP;
            PLLC_ST_SLEEP:
                if (wake_irq_i)
                    mode_nxt = PLLC_ST_RUN;
            PLLC_ST_DEEP:
                if (wake_irq_i)
                    mode_nxt = PLLC_ST_RESTORE;
            PLLC_ST_RESTORE:
                mode_nxt = PLLC_ST_RUN;
            default:
                mode_nxt = PLLC_ST_RUN;
        endcase
    end

    // Clock outputs follow the mode being entered.
    always_comb
    begin
        src_nxt = run_src;
        divisor_nxt = {1'b0, run_div} + 7'h01;
        main_osc_pdn_nxt = 1'b0;
        cpu_en_nxt = (mode_nxt == PLLC_ST_RUN);
        if (mode_nxt == PLLC_ST_DEEP)
        begin
            src_nxt = ds_internal ? PLLC_SRC_INT_OSC : PLLC_SRC_MAIN_OSC;
            main_osc_pdn_nxt = ds_internal;
            if (!pdn_eff)
                divisor_nxt = use_ext ?
                    {1'b0, ds_cfg_r[`PLLC_DS_DIV]} + 7'h01 :
                    {3'h0, ds_cfg_r[3:0]} + 7'h01;
        end
        pdn_nxt = !(!pdn_eff && mode_nxt != PLLC_ST_DEEP);
        iosc_pdn_nxt = !(src_nxt == PLLC_SRC_INT_OSC ||
            osc_eff == PLLC_SRC_INT_OSC);
    end

    // Peripheral gating: restore still holds the deep-sleep gates.
    genvar g;
    generate
        for (g = 0; g < NGATE; g++)
        begin : gate_sel
            always_comb
            begin
                if (mode_nxt == PLLC_ST_RUN || !auto_gate)
                    periph_nxt[g*32 +: 32] = rgate_r[g];
                else if (mode_nxt == PLLC_ST_SLEEP)
                    periph_nxt[g*32 +: 32] = sgate_r[g];
                else
                    periph_nxt[g*32 +: 32] = dgate_r[g];
            end
        end
    endgenerate

    // APB slave with one wait state.
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
    assign rd_en = psel_i && penable_i && !pready_o && !pwrite_i;

    always_comb
    begin
        run_cfg_nxt = run_cfg_r;
        ext_cfg_nxt = ext_cfg_r;
        ds_cfg_nxt = ds_cfg_r;
        mask_nxt = mask_r;
        lock_nxt = lock_r;
        rgate_nxt = rgate_r;
        sgate_nxt = sgate_r;
        dgate_nxt = dgate_r;
        prdata_nxt = 32'h0000_0000;
        pready_nxt = psel_i && penable_i && !pready_o;
        hit = 1'b1;
        unique case (paddr_i)
            `PLLC_OFF_RAW_STAT:
                prdata_nxt[`PLLC_INT_LOCK] = lock_r;
            `PLLC_OFF_INT_MASK:
            begin
                prdata_nxt[`PLLC_INT_LOCK] = mask_r;
                if (wr_en)
                    mask_nxt = pwdata_i[`PLLC_INT_LOCK];
            end
            `PLLC_OFF_INT_CLR:
            begin
                prdata_nxt[`PLLC_INT_LOCK] = lock_r && mask_r;
                if (wr_en && pwdata_i[`PLLC_INT_LOCK])
                    lock_nxt = 1'b0;
            end
            `PLLC_OFF_RUN_CFG:
            begin
                prdata_nxt = run_cfg_r;
                if (wr_en)
                    run_cfg_nxt = pwdata_i;
            end
            `PLLC_OFF_XLATE:
                if (osc_eff == PLLC_SRC_MAIN_OSC)
                    prdata_nxt = {18'h0, pll_cfg_o};
            `PLLC_OFF_RUN_CFG_EXT:
            begin
                prdata_nxt = ext_cfg_r;
                if (wr_en)
                    ext_cfg_nxt = pwdata_i;
            end
            `PLLC_OFF_DSLP_CFG:
            begin
                prdata_nxt = ds_cfg_r;
                if (wr_en)
                    ds_cfg_nxt = pwdata_i;
            end
            default:
                hit = 1'b0;
        endcase
        for (int i = 0; i < NGATE; i++)
        begin
            if (paddr_i == `PLLC_OFF_RUN_GATE + 12'(4 * i))
            begin
                hit = 1'b1;
                prdata_nxt = rgate_r[i];
                if (wr_en)
                    rgate_nxt[i] = pwdata_i;
            end
            if (paddr_i == `PLLC_OFF_SLP_GATE + 12'(4 * i))
            begin
                hit = 1'b1;
                prdata_nxt = sgate_r[i];
                if (wr_en)
                    sgate_nxt[i] = pwdata_i;
            end
            if (paddr_i == `PLLC_OFF_DSLP_GATE + 12'(4 * i))
            begin
                hit = 1'b1;
                prdata_nxt = dgate_r[i];
                if (wr_en)
                    dgate_nxt[i] = pwdata_i;
            end
        end
        if (!rd_en)
            prdata_nxt = 32'h0000_0000;
        pslverr_nxt = pready_nxt && !hit;
        // The lock event beats a clear landing in the same cycle.
        if (main_osc_tick_i && cnt_r == 13'h0001 && pll_on && !trigger)
            lock_nxt = 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        // Hibernate wake arrives here as an ordinary power-on reset.
        if (!rst_n_i)
        begin
            run_cfg_r <= `PLLC_RUN_CFG_RST;
            ext_cfg_r <= `PLLC_RUN_CFG_EXT_RST;
            ds_cfg_r <= `PLLC_DSLP_CFG_RST;
            for (int i = 0; i < NGATE; i++)
            begin
                rgate_r[i] <= (i == 0) ? `PLLC_GATE0_RST : `PLLC_GATEN_RST;
                sgate_r[i] <= (i == 0) ? `PLLC_GATE0_RST : `PLLC_GATEN_RST;
                dgate_r[i] <= (i == 0) ? `PLLC_GATE0_RST : `PLLC_GATEN_RST;
            end
            mask_r <= 1'b0;
            lock_r <= 1'b0;
            crystal_select_prev_r <= 5'(`PLLC_RUN_CFG_RST & 32'h1f);
            pll_on_prev_r <= 1'b0;
            cnt_r <= 13'h0000;
            mode_r <= PLLC_ST_RUN;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            sysclk_src_o <= PLLC_SRC_MAIN_OSC;
            sysclk_divisor_o <= 7'h01;
            pll_prediv2_o <= 1'b0;
            pll_pdn_o <= 1'b1;
            pll_cfg_o <= 14'h0000;
            pll_ref_rtc_o <= 1'b0;
            main_osc_pdn_o <= 1'b0;
            int_osc_pdn_o <= 1'b1;
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= '0;
            pll_lock_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            run_cfg_r <= run_cfg_nxt;
            ext_cfg_r <= ext_cfg_nxt;
            ds_cfg_r <= ds_cfg_nxt;
            rgate_r <= rgate_nxt;
            sgate_r <= sgate_nxt;
            dgate_r <= dgate_nxt;
            mask_r <= mask_nxt;
            lock_r <= lock_nxt;
            crystal_select_prev_r <= crystal_select_prev_nxt;
            pll_on_prev_r <= pll_on_prev_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
            prdata_o <= prdata_nxt;
            pready_o <= pready_nxt;
            pslverr_o <= pslverr_nxt;
            sysclk_src_o <= src_nxt;
            sysclk_divisor_o <= divisor_nxt;
            pll_prediv2_o <= (src_nxt == PLLC_SRC_PLL);
            pll_pdn_o <= pdn_nxt;
            pll_cfg_o <= xlate(run_cfg_r[`PLLC_RC_CRYSTAL_SELECT]);
            pll_ref_rtc_o <= (osc_eff == PLLC_SRC_RTC_OSC);
            main_osc_pdn_o <= main_osc_pdn_nxt;
            int_osc_pdn_o <= iosc_pdn_nxt;
            cpu_clk_en_o <= cpu_en_nxt;
            periph_clk_en_o <= periph_nxt;
            pll_lock_o <= lock_nxt;
            irq_o <= lock_nxt && mask_nxt;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_deep_wake;
        ce_i && mode_r == PLLC_ST_DEEP && wake_irq_i;
    endsequence
    sequence s_restore_then_run;
        ce_i && mode_r == PLLC_ST_RESTORE ##1 mode_r == PLLC_ST_RUN;
    endsequence

    property p_pdn_after_reset;
        $rose(rst_n_i) |-> pll_pdn_o;
    endproperty
    a_pdn_after_reset: assert property (p_pdn_after_reset)
        else $error("PLL not powered down after reset");

    property p_relock_load;
        ce_i && trigger |=> cnt_r == RELOCK_INIT;
    endproperty
    a_relock_load: assert property (p_relock_load)
        else $error("Relock counter not loaded on trigger");

    property p_same_crystal_select;
        ce_i && !trigger && cnt_r == 13'h0000 |=> cnt_r == 13'h0000;
    endproperty
    a_same_crystal_select: assert property (p_same_crystal_select)
        else $error("Relock started without a trigger");

    property p_no_pll_early;
        sysclk_src_o == PLLC_SRC_PLL |-> cnt_r == 13'h0000 && pll_on_prev_r;
    endproperty
    a_no_pll_early: assert property (p_no_pll_early)
        else $error("PLL used before relock expired");

    property p_lock_flag;
        ce_i && main_osc_tick_i && cnt_r == 13'h0001 && pll_on && !trigger
            |=> pll_lock_o ##0 (irq_o == mask_r);
    endproperty
    a_lock_flag: assert property (p_lock_flag)
        else $error("Lock flag or interrupt missed");

    property p_sleep_enter;
        ce_i && mode_r == PLLC_ST_RUN && wfi_i && !deepsleep_en_i
            |=> mode_r == PLLC_ST_SLEEP && !cpu_clk_en_o;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("Sleep not entered on wait instruction");

    property p_sleep_clock;
        ce_i && mode_r == PLLC_ST_SLEEP && !wake_irq_i
            |=> !cpu_clk_en_o && sysclk_src_o == $past(sysclk_src_o);
    endproperty
    a_sleep_clock: assert property (p_sleep_clock)
        else $error("Sleep changed clock or ran core");

    property p_deep_pll_off;
        ce_i && mode_nxt == PLLC_ST_DEEP |=> pll_pdn_o;
    endproperty
    a_deep_pll_off: assert property (p_deep_pll_off)
        else $error("PLL left running in deep-sleep");

    property p_restore_order;
        s_deep_wake |=> !cpu_clk_en_o ##0 s_restore_then_run ##0 cpu_clk_en_o;
    endproperty
    a_restore_order: assert property (p_restore_order)
        else $error("Deep-sleep exit order violated");

endmodule

`default_nettype wire

// ===== rtl/pllc_params.svh
// Purpose: Offsets, field positions, reset values and counts for the PLL
//          relock and sleep clocking block.
// Assumes: Byte offsets on a 32-bit APB bus, one register per word.
// Notes:   Field ranges are written so that reg[`FIELD] selects them.
`ifndef PLLC_PARAMS_SVH
`define PLLC_PARAMS_SVH

`define PLLC_OFF_RAW_STAT 12'h050
`define PLLC_OFF_INT_MASK 12'h054
`define PLLC_OFF_INT_CLR 12'h058
`define PLLC_OFF_RUN_CFG 12'h060
`define PLLC_OFF_XLATE 12'h064
`define PLLC_OFF_RUN_CFG_EXT 12'h070
`define PLLC_OFF_RUN_GATE 12'h100
`define PLLC_OFF_SLP_GATE 12'h110
`define PLLC_OFF_DSLP_GATE 12'h120
`define PLLC_OFF_DSLP_CFG 12'h144

// run_clock_config fields.
`define PLLC_RC_CRYSTAL_SELECT 4:0
`define PLLC_RC_OSC 6:5
`define PLLC_RC_BYPASS 7
`define PLLC_RC_PWRDN 8
`define PLLC_RC_USEDIV 9
`define PLLC_RC_DIV 13:10
`define PLLC_RC_AUTOGATE 14
// run_clock_config_ext fields.
`define PLLC_RX_OSC 2:0
`define PLLC_RX_BYPASS 3
`define PLLC_RX_PWRDN 4
`define PLLC_RX_DIV 10:5
`define PLLC_RX_USE 31
// deepsleep_clock_config fields.
`define PLLC_DS_DIV 5:0
`define PLLC_DS_OSC 7:6
// Interrupt status bit of the PLL lock event.
`define PLLC_INT_LOCK 0

`define PLLC_RUN_CFG_RST 32'h0000_3d8b
`define PLLC_RUN_CFG_EXT_RST 32'h0000_01f8
`define PLLC_DSLP_CFG_RST 32'h0000_0000
`define PLLC_GATE0_RST 32'h0000_0040
`define PLLC_GATEN_RST 32'h0000_0000
`define PLLC_OSC_EXT_RTC 3'h7
`define PLLC_RELOCK_INIT 'h1200
`define PLLC_XLATE_FBASE 9'h190

`endif

// ===== rtl/pllc_pkg.sv
// Purpose: Types shared by the PLL relock and sleep clocking block.
// Assumes: Nothing beyond the params header.
// Notes:   State codes are one-hot.
package pllc_pkg;
    typedef enum logic [3:0] {
        PLLC_ST_RUN = 4'h1,
        PLLC_ST_SLEEP = 4'h2,
        PLLC_ST_DEEP = 4'h4,
        PLLC_ST_RESTORE = 4'h8
    } pllc_mode_t;

    typedef enum logic [1:0] {
        PLLC_SRC_MAIN_OSC = 2'h0,
        PLLC_SRC_INT_OSC = 2'h1,
        PLLC_SRC_RTC_OSC = 2'h2,
        PLLC_SRC_PLL = 2'h3
    } pllc_src_t;
endpackage

// ===== tb/pllc_osc_model.sv
// Purpose: Main oscillator stand-in that emits a counted run of tick pulses.
// Assumes: One tick_o pulse marks one main oscillator period.
// Notes:   Ticks stop once the budget is spent, so relock counts are exact.
`timescale 1ns/1ps
`default_nettype none
module pllc_osc_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [7:0] count_i,
    input wire logic [3:0] period_i,
    output logic tick_o,
    output logic busy_o
);
    logic [7:0] left_r;
    logic [3:0] gap_r;

    // The oscillator is a stable source before the PLL is ever used.
    always_ff @(posedge clk_i)
    begin
        tick_o <= 1'b0;
        if (!rst_n_i)
        begin
            left_r <= 8'h00;
            gap_r <= 4'h0;
        end
        else if (start_i)
        begin
            left_r <= count_i;
            gap_r <= period_i;
        end
        else if (left_r != 8'h00)
        begin
            if (gap_r == 4'h0)
            begin
                tick_o <= 1'b1;
                left_r <= left_r - 8'h01;
                gap_r <= period_i;
            end
            else
                gap_r <= gap_r - 4'h1;
        end
    end

    // Busy covers the last tick too, so a waiter never misses it.
    assign busy_o = (left_r != 8'h00) || tick_o;
endmodule
`default_nettype wire

// ===== tb/pllc_top_tb_top.sv
// Purpose: Self-checking bench for the PLL relock and sleep clocking block.
// Assumes: APB answers with pready_o; ticks come from the oscillator model.
// Notes:   Relock count is shrunk to 8 so that relock runs stay short.
`include "pllc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pllc_top_tb_top import pllc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic wait_for_interrupt_instr = 1'b0;
    logic dse = 1'b0;
    logic wake = 1'b0;
    logic ce = 1'b1;
    logic ostart = 1'b0;
    logic [7:0] ocnt = 8'h00;
    logic [3:0] oper = 4'h0;
    logic [31:0] prdata, rg, sg, dg;
    logic pready, pslverr, tick, pre2, pdn, rtc, mpdn, ipdn, cpu, lock;
    logic irq, obusy;
    logic [1:0] src;
    logic [6:0] div;
    logic [13:0] cfg;
    logic [95:0] gate;
    logic [33:0] mnote;
    logic [33:0] note_q[$];
    int mismatches = 0;
    int comparisons = 0;

    pllc_top #(.NGATE(3), .RELOCK_INIT(13'h8)) dut_u (
        .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .main_osc_tick_i(tick), .wfi_i(wait_for_interrupt_instr),
        .deepsleep_en_i(dse), .wake_irq_i(wake), .sysclk_src_o(src),
        .sysclk_divisor_o(div), .pll_prediv2_o(pre2), .pll_pdn_o(pdn),
        .pll_cfg_o(cfg), .pll_ref_rtc_o(rtc), .main_osc_pdn_o(mpdn),
        .int_osc_pdn_o(ipdn), .cpu_clk_en_o(cpu), .periph_clk_en_o(gate),
        .pll_lock_o(lock), .irq_o(irq));

    pllc_osc_model osc_u (.clk_i(clk), .rst_n_i(rst_n), .start_i(ostart),
        .count_i(ocnt), .period_i(oper), .tick_o(tick), .busy_o(obusy));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Each note holds {write, error expected, read data expected}.
    always @(posedge clk)
    begin
        if (pready === 1'b1)
        begin
            if (note_q.size() == 0)
                chk("stray pready", 32'h0, 32'h1);
            else
            begin
                mnote = note_q.pop_front();
                chk("pslverr", {31'h0, mnote[32]}, {31'h0, pslverr});
                if (!mnote[33])
                    chk("prdata", mnote[31:0], prdata);
            end
        end
    end

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic e);
        int n;
        note_q.push_back({w, e, d});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 40)
        begin
            mismatches++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic ticks(input logic [7:0] k, input logic [3:0] p);
        int n;
        @(posedge clk);
        ostart <= 1'b1;
        ocnt <= k;
        oper <= p;
        @(posedge clk);
        ostart <= 1'b0;
        n = 0;
        @(posedge clk);
        while (obusy !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 400)
        begin
            mismatches++;
            complete_run();
        end
    endtask

    // Pulses one event; the caller samples just after it has been taken.
    task automatic ev(input logic is_wfi);
        @(posedge clk);
        wait_for_interrupt_instr <= is_wfi;
        wake <= !is_wfi;
        @(posedge clk);
        wait_for_interrupt_instr <= 1'b0;
        wake <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_src(input logic [1:0] v);
        int n;
        n = 0;
        while (src !== v && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk("sysclk_src", 32'(v), 32'(src));
    endtask

    initial
    begin
        void'($urandom(32'h16ffd957));
        step(2);
        rst_n <= 1'b1;
        step(2);
        chk("pll_pdn", 32'h1, 32'(pdn));
        chk("sysclk_src", 32'h0, 32'(src));
        apb(1'b0, `PLLC_OFF_RUN_CFG, `PLLC_RUN_CFG_RST, 1'b0);
        apb(1'b0, 12'h0fc, 32'h0, 1'b1);
        rg = $urandom;
        sg = $urandom;
        dg = $urandom;
        wr(`PLLC_OFF_RUN_GATE, rg);
        wr(`PLLC_OFF_SLP_GATE, sg);
        wr(`PLLC_OFF_DSLP_GATE, dg);
        step(2);
        chk("run_gates", rg, gate[31:0]);
        // Crystal code 0x10 is in range; PLL powered up, divisor field 3.
        wr(`PLLC_OFF_RUN_CFG, 32'h0000_0e10);
        step(20);
        chk("src_no_ticks", 32'h0, 32'(src));
        ticks(8'd4, 4'h0);
        wr(`PLLC_OFF_RUN_CFG, 32'h0000_0e11);
        ticks(8'd7, 4'h3);
        step(4);
        chk("src_one_short", 32'h0, 32'(src));
        chk("lock_early", 32'h0, 32'(lock));
        ticks(8'd1, 4'h0);
        wait_src(PLLC_SRC_PLL);
        chk("lock", 32'h1, 32'(lock));
        chk("pll_pdn", 32'h0, 32'(pdn));
        chk("divisor", 32'h4, 32'(div));
        chk("prediv2", 32'h1, 32'(pre2));
        chk("pll_cfg", 32'h0000_237f, 32'(cfg));
        apb(1'b0, `PLLC_OFF_XLATE, 32'h0000_237f, 1'b0);
        wr(`PLLC_OFF_RUN_CFG, 32'h0000_0e11);
        step(10);
        chk("same_crystal_select_src", 32'h3, 32'(src));
        wr(`PLLC_OFF_INT_MASK, 32'h1);
        step(2);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b0, `PLLC_OFF_RAW_STAT, 32'h1, 1'b0);
        wr(`PLLC_OFF_INT_CLR, 32'h1);
        step(2);
        chk("lock_clr", 32'h0, 32'(lock));
        chk("irq_clr", 32'h0, 32'(irq));
        ev(1'b1);
        chk("sleep_cpu", 32'h0, 32'(cpu));
        chk("sleep_src", 32'h3, 32'(src));
        chk("sleep_div", 32'h4, 32'(div));
        chk("sleep_gates", rg, gate[31:0]);
        ev(1'b0);
        chk("wake_cpu", 32'h1, 32'(cpu));
        // A wait instruction seen while frozen must be lost.
        ce <= 1'b0;
        ev(1'b1);
        ce <= 1'b1;
        chk("ce_freeze_cpu", 32'h1, 32'(cpu));
        wr(`PLLC_OFF_RUN_CFG, 32'h0000_4e11);
        ev(1'b1);
        chk("auto_gates", sg, gate[31:0]);
        ev(1'b0);
        wr(`PLLC_OFF_DSLP_CFG, 32'h5);
        dse <= 1'b1;
        ev(1'b1);
        chk("deep_pdn", 32'h1, 32'(pdn));
        chk("deep_src", 32'h0, 32'(src));
        chk("deep_div", 32'h6, 32'(div));
        chk("deep_cpu", 32'h0, 32'(cpu));
        chk("deep_gates", dg, gate[31:0]);
        chk("deep_main_osc_pdn", 32'h0, 32'(mpdn));
        chk("deep_iosc_pdn", 32'h1, 32'(ipdn));
        ev(1'b0);
        // Waking powers the PLL up again, so the oscillator clocks the
        // system until the new relock expires.
        chk("restore_src", 32'h0, 32'(src));
        chk("restore_div", 32'h4, 32'(div));
        chk("restore_cpu", 32'h0, 32'(cpu));
        // Wake stimulus lets a cycle pass before touching peripherals.
        step(1);
        chk("run_cpu", 32'h1, 32'(cpu));
        chk("run_gates_back", rg, gate[31:0]);
        ticks(8'd8, 4'h0);
        wait_src(PLLC_SRC_PLL);
        dse <= 1'b0;
        wr(`PLLC_OFF_RUN_CFG_EXT, 32'h8000_00a7);
        step(3);
        chk("ref_rtc", 32'h1, 32'(rtc));
        chk("ext_div", 32'h6, 32'(div));
        apb(1'b0, `PLLC_OFF_XLATE, 32'h0, 1'b0);
        step(2);
        complete_run();
    end

    initial
    begin
        #750000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
